/* File: hdl/limg_defs.svh */
// Register offsets, field positions and reset values for the interrupt mask gate
`ifndef LIMG_DEFS_SVH
`define LIMG_DEFS_SVH

`define LIMG_ADDR_W 8
`define LIMG_OFS_MASK_SET 8'h88
`define LIMG_OFS_MASK_CLR 8'h8c
`define LIMG_OFS_EVENT 8'h80
`define LIMG_OFS_ISO_TX_EVENT 8'h90
`define LIMG_OFS_ISO_TX_MASK 8'h98
`define LIMG_OFS_ISO_RX_EVENT 8'ha0
`define LIMG_OFS_ISO_RX_MASK 8'ha8
`define LIMG_OFS_STATUS 8'hc0
`define LIMG_BIT_GLOBAL 31
`define LIMG_BIT_MAKER 30
`define LIMG_BIT_SOFT 29
`define LIMG_BIT_ISO_RX 7
`define LIMG_BIT_ISO_TX 6
`define LIMG_MASK_WRITABLE 32'hefff83ff
`define LIMG_MASK_RESET 32'h00000000
`define LIMG_ISO_TX_W 8
`define LIMG_ISO_RX_W 4
`define LIMG_RESP_OKAY 2'h0
`define LIMG_RESP_SLVERR 2'h2

`endif

/* File: hdl/limg_pkg.sv */
// Types for the interrupt mask gate
package limg_pkg;
  typedef enum logic [1:0] {
    limg_wr_idle,
    limg_wr_resp
  } limg_wr_e;
  typedef struct packed {
    logic [31:0] mask;
    logic [7:0] iso_tx_mask;
    logic [3:0] iso_rx_mask;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    limg_wr_e wr_state;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
  } limg_state_s;
endpackage

/* File: hdl/limg_gate.sv */
// Interrupt mask register with set/clear ports and gated interrupt output over AXI4-Lite
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "limg_defs.svh"

module limg_gate
  import limg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] event_bits,
  input wire logic [7:0] iso_tx_events,
  input wire logic [3:0] iso_rx_events,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State and combinational helpers
  limg_state_s cur;
  limg_state_s nxt;
  logic [31:0] ev_eff;
  logic [31:0] pending;
  logic [31:0] byte_mask;
  logic [31:0] wbits;
  logic [31:0] rd_word;
  logic rd_ok;
  logic aw_take;
  logic w_take;

  ////////////////////////////////////////////////////////////////////////////
  // Per-lane strobe expansion
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign byte_mask[gi*8 +: 8] = {8{cur.w_strb[gi]}};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Effective event word: iso summaries replaced by live per-context products
  always_comb begin
    ev_eff = event_bits;
    ev_eff[`LIMG_BIT_ISO_RX] = |(iso_rx_events & cur.iso_rx_mask);
    ev_eff[`LIMG_BIT_ISO_TX] = |(iso_tx_events & cur.iso_tx_mask);
  end

  // Same bit position pairs event with mask; reserved mask bits are zero
  assign pending = ev_eff & cur.mask;

  ////////////////////////////////////////////////////////////////////////////
  // Read decode
  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h00000000;
    case (s_axi_araddr)
      `LIMG_OFS_MASK_SET,
      `LIMG_OFS_MASK_CLR: rd_word = cur.mask;
      `LIMG_OFS_ISO_TX_MASK: rd_word = {24'h000000, cur.iso_tx_mask};
      `LIMG_OFS_ISO_RX_MASK: rd_word = {28'h0000000, cur.iso_rx_mask};
      `LIMG_OFS_STATUS: rd_word = pending;
      default: rd_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus handshakes and set/clear updates
  assign aw_take = s_axi_awvalid && !cur.aw_held && cur.wr_state == limg_wr_idle;
  assign w_take = s_axi_wvalid && !cur.w_held && cur.wr_state == limg_wr_idle;

  always_comb begin
    nxt = cur;
    wbits = cur.w_data & byte_mask;
    if (aw_take) begin
      nxt.aw_held = 1'b1;
      nxt.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      nxt.w_held = 1'b1;
      nxt.w_data = s_axi_wdata;
      nxt.w_strb = s_axi_wstrb;
    end
    case (cur.wr_state)
      limg_wr_idle: begin
        // Address and data both held: perform the write and raise the answer on the same edge
        if (cur.aw_held && cur.w_held) begin
          nxt.aw_held = 1'b0;
          nxt.w_held = 1'b0;
          nxt.wr_state = limg_wr_resp;
          nxt.bresp = `LIMG_RESP_OKAY;
          case (cur.aw_addr)
            `LIMG_OFS_MASK_SET: nxt.mask = (cur.mask | wbits) & `LIMG_MASK_WRITABLE;
            `LIMG_OFS_MASK_CLR: nxt.mask = cur.mask & ~wbits & `LIMG_MASK_WRITABLE;
            `LIMG_OFS_ISO_TX_MASK: nxt.iso_tx_mask = cur.iso_tx_mask | wbits[7:0];
            `LIMG_OFS_ISO_TX_MASK + 8'h04: nxt.iso_tx_mask = cur.iso_tx_mask & ~wbits[7:0];
            `LIMG_OFS_ISO_RX_MASK: nxt.iso_rx_mask = cur.iso_rx_mask | wbits[3:0];
            `LIMG_OFS_ISO_RX_MASK + 8'h04: nxt.iso_rx_mask = cur.iso_rx_mask & ~wbits[3:0];
            `LIMG_OFS_STATUS: nxt.bresp = `LIMG_RESP_OKAY;
            default: nxt.bresp = `LIMG_RESP_SLVERR;
          endcase
        end
      end
      limg_wr_resp: begin
        if (s_axi_bready) begin
          nxt.wr_state = limg_wr_idle;
        end
      end
      default: nxt.wr_state = limg_wr_idle;
    endcase
    // Read channel: one read in flight, data registered
    if (cur.rvalid) begin
      if (s_axi_rready) begin
        nxt.rvalid = 1'b0;
      end
    end else if (s_axi_arvalid) begin
      nxt.rvalid = 1'b1;
      nxt.rdata = rd_word;
      nxt.rresp = rd_ok ? `LIMG_RESP_OKAY : `LIMG_RESP_SLVERR;
    end
    // Registered gated interrupt; global enable overrides every source
    nxt.irq = cur.mask[`LIMG_BIT_GLOBAL] && |pending[`LIMG_BIT_GLOBAL-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cur <= '0;
      cur.mask <= `LIMG_MASK_RESET;
      cur.wr_state <= limg_wr_idle;
    end else begin
      cur <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port drive
  assign s_axi_awready = !cur.aw_held && cur.wr_state == limg_wr_idle;
  assign s_axi_wready = !cur.w_held && cur.wr_state == limg_wr_idle;
  assign s_axi_bvalid = cur.wr_state == limg_wr_resp;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_arready = !cur.rvalid;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rdata = cur.rdata;
  assign s_axi_rresp = cur.rresp;
  assign irq = cur.irq;

endmodule

/* File: verif/limg_gate_checker.sv */
// Bus handshake and read-value checks for the interrupt mask gate
`timescale 1ns/100ps
module limg_chk(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  // Single domain, so one clock and reset serve all
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_block: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read accept while busy");
  a_wr_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accept while busy");
  a_rsvd_zero: assert property (s_axi_rvalid |-> !s_axi_rdata[28] && s_axi_rdata[14:10] == 5'h0)
    else $error("reserved bits set");
  a_bad_addr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h84
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read answer");
  // Main traffic kinds seen at least once
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_error: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind limg_gate limg_chk i_chk(.*);

/* File: verif/test_limg_gate.sv */
// Self-checking bench for the interrupt mask gate
`timescale 1ns/100ps
module test_limg_gate;
  logic clk_sys = 1'h0;
  logic srst = 1'h1;
  // Answer channels always ready, which keeps each driver to one assignment a step
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, iso_tx_events = '0;
  logic [31:0] s_axi_wdata = '0, event_bits = '0, d, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, iso_rx_events = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int mismatches = 0, checks = 0;
  logic [71:0] rows [5] = '{{8'h88, 32'hffffffff, 32'hefff83ff}, {8'h8c, 32'h0000ffff, 32'hefff0000},
    {8'h8c, 32'h80000000, 32'h6fff0000}, {8'h88, 32'h00000005, 32'h6fff0005}, {8'h8c, 32'hffffffff, 32'h0}};
  limg_gate i_dut(.*);
  initial forever #20 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Readiness is looked at on the falling edge so the taking edge is known ahead
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do @(negedge clk_sys); while (!(s_axi_awready && s_axi_wready));
    @(posedge clk_sys);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    do @(negedge clk_sys); while (!s_axi_bvalid);
    cmp(32'(s_axi_bresp), 32'h0);
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(negedge clk_sys); while (!s_axi_arready);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'h0;
    do @(negedge clk_sys); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk_sys);
  endtask
  // Output is registered, so two edges after the event change it has settled
  task automatic irqt(input logic [31:0] m, input logic [31:0] e, input logic x);
    wr(8'h8c, 32'hffffffff);
    wr(8'h88, m);
    event_bits <= e;
    repeat (2) @(posedge clk_sys);
    cmp(32'(irq), 32'(x));
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'h0;
    rd(8'h88);
    cmp(d, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(rows[i][71:64], rows[i][63:32]);
      rd(8'h88);
      cmp(d, rows[i][31:0]);
      rd(8'h8c);
      cmp(d, rows[i][31:0]);
    end
    $display("mask rows done");
    for (int b = 0; b < 31; b++) begin
      if (b == 28 || (b > 9 && b < 15) || b == 7 || b == 6) continue;
      irqt(32'h80000000 | (32'h1 << b), 32'h1 << b, 1'h1);
      irqt(32'h1 << b, 32'h1 << b, 1'h0);
      irqt(32'h80000000 | (32'h1 << b), ~(32'h1 << b), 1'h0);
    end
    $display("event bits done");
    wr(8'ha8, 32'h2);
    wr(8'h98, 32'h10);
    iso_rx_events <= 4'h2;
    irqt(32'h80000080, 32'h0, 1'h1);
    iso_rx_events <= 4'h1;
    irqt(32'h80000080, 32'h80, 1'h0);
    iso_tx_events <= 8'h10;
    irqt(32'h80000040, 32'h0, 1'h1);
    $display("summaries done");
    // Per-context transmit mask reads back, and the pending word shows the live summary
    rd(8'h98);
    cmp(d, 32'h00000010);
    rd(8'hc0);
    cmp(d, 32'h00000040);
    rd(8'h84);
    cmp(32'(r), 32'h2);
    srst <= 1'h1;
    @(posedge clk_sys);
    srst <= 1'h0;
    rd(8'h88);
    cmp(d, 32'h0);
    // Interrupt was high before the reset; a cleared mask must hold it low
    cmp(32'(irq), 32'h0);
    $display("reset and errors done");
    summarize();
  end
  // Whole run is near 640 cycles, so this bound only trips on a hang
  initial begin
    #400000;
    mismatches++;
    summarize();
  end
endmodule
